// ==== i2c_soft_reset_call_pkg.sv ====
// Shared constants, types and helpers for both ends of the reset-call link.
package i2c_soft_reset_call_pkg;

  localparam logic [7:0] RESET_CALL_ADDR = 8'h06;
  localparam logic [7:0] RESET_KEY_FIRST = 8'hA5;
  localparam logic [7:0] RESET_KEY_SECOND = 8'h5A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 320;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYC - 1);
  localparam int BUS_FREE_INTERVAL_NS = 500;
  localparam int BUS_FREE_CYC =
    (BUS_FREE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BUS_FREE_LAST = 8'(BUS_FREE_CYC - 1);

  typedef enum logic [2:0] {
    PH_ADDR,
    PH_KEY1,
    PH_KEY2,
    PH_EXTRA,
    PH_IGNORE
  } call_phase_type;

  typedef enum logic [3:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_ACK,
    M_STOP_LOW,
    M_STOP_CLK,
    M_STOP_DATA,
    M_FREE
  } master_state_type;

  // Whether the device acknowledges a byte received in the given phase.
  function automatic logic ack_ok(call_phase_type ph, logic [7:0] rx);
    case (ph)
      PH_ADDR: ack_ok = (rx == RESET_CALL_ADDR);
      PH_KEY1: ack_ok = (rx == RESET_KEY_FIRST);
      PH_KEY2: ack_ok = (rx == RESET_KEY_SECOND);
      default: ack_ok = 1'b0;
    endcase
  endfunction

endpackage

// ==== i2c_link_if.sv ====
// Two-wire open-drain link joining the bus master and the reset-call device.
interface i2c_link_if;
  logic sclMstOut;
  logic sclMstOe;
  logic sdaMstOut;
  logic sdaMstOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;

  // Pull-ups hold both wires high unless some end drives a low.
  assign scl = ~(sclMstOe & ~sclMstOut);
  assign sda = ~((sdaMstOe & ~sdaMstOut) | (sdaDevOe & ~sdaDevOut));

  modport master (
    input scl,
    input sda,
    output sclMstOut,
    output sclMstOe,
    output sdaMstOut,
    output sdaMstOe
  );

  modport device (
    input scl,
    input sda,
    output sdaDevOut,
    output sdaDevOe
  );
endinterface

// ==== i2c_soft_reset_call_device.sv ====
// Device end: recognises the reset call on the link and pulses a reset.

module i2c_soft_reset_call_device (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  i2c_link_if.device link,
  output logic softResetCall,
  output logic busFree,
  output logic callArmed
);
  import i2c_soft_reset_call_pkg::*;

  // State sampled on the rising link clock edge.
  typedef struct packed {
    logic [7:0] shift;
    logic [3:0] bitCnt;
    call_phase_type phase;
    logic armed;
  } link_rise_type;

  // State updated on the falling link clock edge.
  typedef struct packed {
    logic sdaOe;
    logic fresh;
    logic seenTog;
  } link_fall_type;

  // State in the system clock domain.
  typedef struct packed {
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic sclLvl;
    logic sdaLvl;
    logic [1:0] armedSync;
    logic softResetCall;
    logic busFree;
    logic freeCounting;
    logic [7:0] freeCnt;
  } sys_type;

  localparam link_rise_type RISE_RESET = '{
    shift: 8'h00,
    bitCnt: 4'h0,
    phase: PH_IGNORE,
    armed: 1'b0
  };

  localparam link_fall_type FALL_RESET = '{
    sdaOe: 1'b0,
    fresh: 1'b0,
    seenTog: 1'b0
  };

  localparam sys_type SYS_RESET = '{
    sclSync: 3'h7,
    sdaSync: 3'h7,
    sclLvl: 1'b1,
    sdaLvl: 1'b1,
    armedSync: 2'h0,
    softResetCall: 1'b0,
    busFree: 1'b1,
    freeCounting: 1'b0,
    freeCnt: 8'h00
  };

  link_rise_type rise_ff;
  link_rise_type nxt_rise;
  link_fall_type fall_ff;
  link_fall_type nxt_fall;
  sys_type sys_ff;
  sys_type nxt_sys;
  logic startTog_ff;

  // A START is a data fall while the clock is high, so it is caught on the
  // data wire itself. The clock-edge logic reads the toggle only at the next
  // clock fall, which the protocol's start hold time keeps well after it.
  always_ff @(negedge link.sda or negedge rst_n) begin
    if (!rst_n) begin
      startTog_ff <= 1'b0;
    end else if (clkEn && link.scl) begin
      startTog_ff <= ~startTog_ff;
    end
  end

  always_comb begin
    logic ok;
    ok = 1'b0;
    nxt_rise = rise_ff;
    if (!rst_n) begin
      nxt_rise = RISE_RESET;
    end else if (clkEn) begin
      if (fall_ff.fresh) begin
        // First bit of a new frame throws away any partial sequence.
        nxt_rise.shift = {7'h00, link.sda};
        nxt_rise.bitCnt = 4'h1;
        nxt_rise.phase = PH_ADDR;
        nxt_rise.armed = 1'b0;
      end else if (rise_ff.bitCnt == BITS_PER_BYTE) begin
        // Acknowledge slot: decide where the call goes next.
        nxt_rise.bitCnt = 4'h0;
        ok = ack_ok(rise_ff.phase, rise_ff.shift);
        case (rise_ff.phase)
          PH_ADDR: begin
            nxt_rise.phase = ok ? PH_KEY1 : PH_IGNORE;
          end
          PH_KEY1: begin
            nxt_rise.phase = ok ? PH_KEY2 : PH_IGNORE;
          end
          PH_KEY2: begin
            nxt_rise.phase = ok ? PH_EXTRA : PH_IGNORE;
            nxt_rise.armed = ok;
          end
          PH_EXTRA: begin
            // A fourth byte spoils an otherwise good call.
            nxt_rise.phase = PH_IGNORE;
            nxt_rise.armed = 1'b0;
          end
          default: begin
            nxt_rise.phase = PH_IGNORE;
          end
        endcase
      end else begin
        nxt_rise.shift = {rise_ff.shift[6:0], link.sda};
        nxt_rise.bitCnt = rise_ff.bitCnt + 4'h1;
      end
    end
  end

  always_comb begin
    nxt_fall = fall_ff;
    if (!rst_n) begin
      nxt_fall.sdaOe = 1'b0;
      nxt_fall.fresh = 1'b0;
      nxt_fall.seenTog = startTog_ff;
    end else if (clkEn) begin
      nxt_fall.seenTog = startTog_ff;
      nxt_fall.fresh = (startTog_ff != fall_ff.seenTog);
      // Drive low from the fall before the ninth clock to the fall after it,
      // so the line is steady through the whole high phase of that clock.
      nxt_fall.sdaOe = !nxt_fall.fresh &&
        (rise_ff.bitCnt == BITS_PER_BYTE) &&
        ack_ok(rise_ff.phase, rise_ff.shift);
      // The device never transmits data; outside its own acknowledge the
      // line is always released, read calls included.
    end
  end

  always_comb begin
    logic startEv;
    logic stopEv;
    startEv = 1'b0;
    stopEv = 1'b0;
    nxt_sys = sys_ff;
    if (!rst_n) begin
      nxt_sys = SYS_RESET;
    end else if (clkEn) begin
      nxt_sys.sclSync = {sys_ff.sclSync[1:0], link.scl};
      nxt_sys.sdaSync = {sys_ff.sdaSync[1:0], link.sda};
      nxt_sys.armedSync = {sys_ff.armedSync[0], rise_ff.armed};
      if (sys_ff.sclSync[1] == sys_ff.sclSync[2]) begin
        nxt_sys.sclLvl = sys_ff.sclSync[2];
      end
      if (sys_ff.sdaSync[1] == sys_ff.sdaSync[2]) begin
        nxt_sys.sdaLvl = sys_ff.sdaSync[2];
      end
      startEv = sys_ff.sclLvl && nxt_sys.sclLvl &&
        sys_ff.sdaLvl && !nxt_sys.sdaLvl;
      stopEv = sys_ff.sclLvl && nxt_sys.sclLvl &&
        !sys_ff.sdaLvl && nxt_sys.sdaLvl;
      nxt_sys.softResetCall = stopEv && sys_ff.armedSync[1];
      if (startEv) begin
        nxt_sys.busFree = 1'b0;
        nxt_sys.freeCounting = 1'b0;
      end else if (stopEv) begin
        nxt_sys.freeCounting = 1'b1;
        nxt_sys.freeCnt = 8'h00;
      end else if (sys_ff.freeCounting) begin
        if (sys_ff.freeCnt == BUS_FREE_LAST) begin
          nxt_sys.busFree = 1'b1;
          nxt_sys.freeCounting = 1'b0;
        end else begin
          nxt_sys.freeCnt = sys_ff.freeCnt + 8'h01;
        end
      end
    end
  end

  // The link clock stands still while reset is held, so the link-side
  // flops take reset at once rather than wait for an edge that never comes.
  always_ff @(posedge link.scl or negedge rst_n) begin
    if (!rst_n) begin
      rise_ff <= RISE_RESET;
    end else begin
      rise_ff <= nxt_rise;
    end
  end

  always_ff @(negedge link.scl or negedge rst_n) begin
    if (!rst_n) begin
      fall_ff <= FALL_RESET;
    end else begin
      fall_ff <= nxt_fall;
    end
  end

  always_ff @(posedge sys_clk) begin
    sys_ff <= nxt_sys;
  end

  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe = fall_ff.sdaOe;
  assign softResetCall = sys_ff.softResetCall;
  assign busFree = sys_ff.busFree;
  assign callArmed = sys_ff.armedSync[1];

endmodule

// ==== i2c_soft_reset_call_master.sv ====
// Master end: sends a frame of up to four bytes and reports the outcome.
module i2c_soft_reset_call_master (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  i2c_link_if.master link,
  input wire logic sendReq,
  input wire logic [7:0] addrByte,
  input wire logic [7:0] dataFirst,
  input wire logic [7:0] dataSecond,
  input wire logic [7:0] dataThird,
  input wire logic [1:0] dataCount,
  output logic busy,
  output logic done,
  output logic aborted
);
  import i2c_soft_reset_call_pkg::*;

  typedef struct packed {
    master_state_type state;
    logic [7:0] tick;
    logic [1:0] quarter;
    logic [2:0] bitCnt;
    logic [1:0] byteIdx;
    logic [1:0] count;
    logic [31:0] frame;
    logic [7:0] shift;
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic sclLvl;
    logic sdaLvl;
    logic sclLow;
    logic sdaLow;
    logic busy;
    logic done;
    logic aborted;
  } master_type;

  master_type m_ff;
  master_type nxt_m;

  function automatic logic [7:0] pick(logic [31:0] f, logic [1:0] i);
    pick = f[8'(31 - 8 * int'(i)) -: 8];
  endfunction

  always_comb begin
    logic step;
    step = 1'b0;
    nxt_m = m_ff;
    if (!rst_n) begin
      nxt_m = '0;
      nxt_m.state = M_IDLE;
      nxt_m.sclSync = 3'h7;
      nxt_m.sdaSync = 3'h7;
      nxt_m.sclLvl = 1'b1;
      nxt_m.sdaLvl = 1'b1;
    end else if (clkEn) begin
      nxt_m.done = 1'b0;
      nxt_m.sclSync = {m_ff.sclSync[1:0], link.scl};
      nxt_m.sdaSync = {m_ff.sdaSync[1:0], link.sda};
      if (m_ff.sclSync[1] == m_ff.sclSync[2]) begin
        nxt_m.sclLvl = m_ff.sclSync[2];
      end
      if (m_ff.sdaSync[1] == m_ff.sdaSync[2]) begin
        nxt_m.sdaLvl = m_ff.sdaSync[2];
      end
      step = (m_ff.tick == QUARTER_LAST);
      nxt_m.tick = step ? 8'h00 : m_ff.tick + 8'h01;
      case (m_ff.state)
        M_IDLE: begin
          if (!m_ff.busy && sendReq) begin
            nxt_m.busy = 1'b1;
            nxt_m.aborted = 1'b0;
            nxt_m.frame = {addrByte, dataFirst, dataSecond, dataThird};
            nxt_m.count = dataCount;
          end else if (m_ff.busy && step && m_ff.sclLvl && m_ff.sdaLvl) begin
            nxt_m.sdaLow = 1'b1;
            nxt_m.state = M_START;
          end
        end
        M_START: begin
          if (step) begin
            nxt_m.sclLow = 1'b1;
            nxt_m.shift = pick(m_ff.frame, 2'h0);
            nxt_m.byteIdx = 2'h0;
            nxt_m.bitCnt = 3'h0;
            nxt_m.quarter = 2'h0;
            nxt_m.state = M_BIT;
          end
        end
        M_BIT: begin
          if (step) begin
            nxt_m.quarter = m_ff.quarter + 2'h1;
            case (m_ff.quarter)
              2'h0: nxt_m.sdaLow = !m_ff.shift[7];
              2'h1: nxt_m.sclLow = 1'b0;
              2'h3: begin
                nxt_m.sclLow = 1'b1;
                nxt_m.shift = {m_ff.shift[6:0], 1'b0};
                nxt_m.bitCnt = m_ff.bitCnt + 3'h1;
                if (m_ff.bitCnt == LAST_BIT) begin
                  nxt_m.state = M_ACK;
                end
              end
              default: nxt_m.sclLow = m_ff.sclLow;
            endcase
          end
        end
        M_ACK: begin
          if (step) begin
            nxt_m.quarter = m_ff.quarter + 2'h1;
            case (m_ff.quarter)
              2'h0: nxt_m.sdaLow = 1'b0;
              2'h1: nxt_m.sclLow = 1'b0;
              2'h2: nxt_m.aborted = m_ff.sdaLvl;
              2'h3: begin
                // The master only ever transmits, read addresses included, so it never has to
                // acknowledge or refuse data itself.
                nxt_m.sclLow = 1'b1;
                if (m_ff.aborted || m_ff.byteIdx == m_ff.count) begin
                  nxt_m.state = M_STOP_LOW;
                end else begin
                  nxt_m.byteIdx = m_ff.byteIdx + 2'h1;
                  nxt_m.shift = pick(m_ff.frame, m_ff.byteIdx + 2'h1);
                  nxt_m.state = M_BIT;
                end
              end
              default: nxt_m.sclLow = m_ff.sclLow;
            endcase
          end
        end
        M_STOP_LOW: begin
          if (step) begin
            nxt_m.sdaLow = 1'b1;
            nxt_m.state = M_STOP_CLK;
          end
        end
        M_STOP_CLK: begin
          if (step) begin
            nxt_m.sclLow = 1'b0;
            nxt_m.state = M_STOP_DATA;
          end
        end
        M_STOP_DATA: begin
          if (step) begin
            nxt_m.sdaLow = 1'b0;
            nxt_m.tick = 8'h00;
            nxt_m.state = M_FREE;
          end
        end
        M_FREE: begin
          // Hold off the next frame for the bus free interval.
          nxt_m.tick = m_ff.tick + 8'h01;
          if (m_ff.tick == BUS_FREE_LAST) begin
            nxt_m.tick = 8'h00;
            nxt_m.busy = 1'b0;
            nxt_m.done = 1'b1;
            nxt_m.state = M_IDLE;
          end
        end
        default: nxt_m.state = M_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    m_ff <= nxt_m;
  end

  assign link.sclMstOut = 1'b0;
  assign link.sclMstOe = m_ff.sclLow;
  assign link.sdaMstOut = 1'b0;
  assign link.sdaMstOe = m_ff.sdaLow;
  assign busy = m_ff.busy;
  assign done = m_ff.done;
  assign aborted = m_ff.aborted;

endmodule

// ==== i2c_soft_reset_call_link_monitor.sv ====
// Checker for framing and acknowledge decisions seen on the two wires.
module i2c_soft_reset_call_link_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaMstOe,
  input wire logic sdaDevOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shByte;
  logic [3:0] bitCnt;
  logic [1:0] byteIdx;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Bytes are rebuilt from the wires alone, so a decoding slip in the
  // device cannot hide behind the same slip here.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ($fell(sda) && scl)) begin
      bitCnt <= 4'h0;
      byteIdx <= 2'h0;
    end else if ($rose(scl) && bitCnt == 4'h8) begin
      bitCnt <= 4'h0;
      byteIdx <= (byteIdx == 2'h3) ? byteIdx : byteIdx + 2'h1;
    end else if ($rose(scl)) begin
      shByte <= {shByte[6:0], sda};
      bitCnt <= bitCnt + 4'h1;
    end
  end

  sequence startCond;
    $fell(sda) && scl;
  endsequence

  sequence devAck;
    sdaDevOe && !sda;
  endsequence

  a_addr_ack: assert property (
    $rose(scl) && bitCnt == 4'h8 && byteIdx == 2'h0
    |-> !sda == (shByte == 8'h06)) else $error("address ack wrong");
  a_first_key: assert property (
    $rose(scl) && bitCnt == 4'h8 && byteIdx == 2'h1
    |-> !sda == (shByte == 8'hA5)) else $error("first key ack wrong");
  a_second_key: assert property (
    $rose(scl) && bitCnt == 4'h8 && byteIdx == 2'h2
    |-> !sda == (shByte == 8'h5A)) else $error("second key ack wrong");
  a_extra_nak: assert property (
    $rose(scl) && bitCnt == 4'h8 && byteIdx == 2'h3 |-> sda)
    else $error("extra byte acknowledged");
  a_ack_held: assert property (
    $rose(scl) && sdaDevOe |-> devAck [*8])
    else $error("ack not held through clock high");
  a_ack_length: assert property (
    $rose(sdaDevOe) |-> sdaDevOe [*8] ##[1:40] !sdaDevOe)
    else $error("ack length wrong");
  a_dev_change: assert property (
    $changed(sdaDevOe) |-> !scl) else $error("device moved data at high");
  a_start_clock: assert property (
    startCond |-> ##[1:16] !scl) else $error("no clock after start");
  a_stop_idle: assert property (
    $rose(sda) && scl |-> (sda && scl) [*8])
    else $error("bus not idle after stop");
  a_idle_start: assert property (
    $rose(sdaMstOe) && scl |-> $past(sda, 2))
    else $error("start on busy bus");
endmodule

// ==== i2c_soft_reset_call_slave_tb.sv ====
// Bench joining master and device ends and judging reset calls.
module i2c_soft_reset_call_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  logic clkEn = 1'b1;
  logic sendReq = 1'b0;
  logic [7:0] addrByte = 8'h00;
  logic [7:0] dataFirst = 8'h00;
  logic [7:0] dataSecond = 8'h00;
  logic [7:0] dataThird = 8'h00;
  logic [1:0] dataCount = 2'h0;
  logic busy, done, aborted, softResetCall, busFree, callArmed;
  logic armSeen = 1'b0;
  int errTotal = 0;
  int cmpCount = 0;
  int pulseCnt = 0;
  int cycCnt = 0;

  i2c_link_if i2c_link_if_i ();
  i2c_soft_reset_call_master i2c_soft_reset_call_master_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .link(i2c_link_if_i.master), .sendReq(sendReq),
    .addrByte(addrByte), .dataFirst(dataFirst),
    .dataSecond(dataSecond), .dataThird(dataThird),
    .dataCount(dataCount), .busy(busy), .done(done), .aborted(aborted));
  i2c_soft_reset_call_device i2c_soft_reset_call_device_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .link(i2c_link_if_i.device), .softResetCall(softResetCall),
    .busFree(busFree), .callArmed(callArmed));
  i2c_soft_reset_call_link_monitor i2c_soft_reset_call_link_monitor_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl(i2c_link_if_i.scl),
    .sda(i2c_link_if_i.sda), .sdaMstOe(i2c_link_if_i.sdaMstOe),
    .sdaDevOe(i2c_link_if_i.sdaDevOe));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Eight frames take under ten thousand cycles; the ceiling cuts a hang.
  always @(posedge sys_clk) begin
    cycCnt <= cycCnt + 1;
    if (softResetCall === 1'b1) pulseCnt <= pulseCnt + 1;
    if (callArmed === 1'b1) armSeen <= 1'b1;
    if (cycCnt == 20000) begin
      errTotal = errTotal + 1;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] a, input logic [7:0] k1,
      input logic [7:0] k2, input logic [1:0] n);
    int w;
    @(posedge sys_clk);
    addrByte <= a;
    dataFirst <= k1;
    dataSecond <= k2;
    dataThird <= 8'hC3;
    dataCount <= n;
    sendReq <= 1'b1;
    @(posedge sys_clk);
    sendReq <= 1'b0;
    @(negedge sys_clk);
    chk("busy", 8'h01, {7'h00, busy});
    armSeen = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 6000) begin
      @(negedge sys_clk);
      w++;
    end
    chk("done", 8'h01, {7'h00, done});
    chk("busy", 8'h00, {7'h00, busy});
    // The device's free timer starts behind its input filter, a few
    // cycles after the master's own, so let it catch up.
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic t_good_call();
    int base;
    base = pulseCnt;
    send(8'h06, 8'hA5, 8'h5A, 2'h2);
    chk("aborted", 8'h00, {7'h00, aborted});
    chk("armed", 8'h01, {7'h00, armSeen});
    chk("pulses", 8'h01, 8'(pulseCnt - base));
    chk("busFree", 8'h01, {7'h00, busFree});
  endtask

  // Wrong address, read direction, wrong keys and a surplus byte.
  task automatic t_bad_calls();
    logic [7:0] adr [5] = '{8'h07, 8'h86, 8'h06, 8'h06, 8'h06};
    logic [7:0] ka [5] = '{8'hA5, 8'hA5, 8'hA4, 8'hA5, 8'hA5};
    logic [7:0] kb [5] = '{8'h5A, 8'h5A, 8'h5A, 8'h5B, 8'h5A};
    logic [1:0] cnt [5] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
    int base;
    for (int i = 0; i < 5; i++) begin
      base = pulseCnt;
      send(adr[i], ka[i], kb[i], cnt[i]);
      chk("aborted", 8'h01, {7'h00, aborted});
      chk("pulses", 8'h00, 8'(pulseCnt - base));
    end
  endtask

  // After refused frames the device must take a full call at once.
  task automatic t_again();
    int base;
    base = pulseCnt;
    chk("busFree", 8'h01, {7'h00, busFree});
    send(8'h06, 8'hA5, 8'h5A, 2'h2);
    chk("aborted", 8'h00, {7'h00, aborted});
    send(8'h06, 8'hA5, 8'h5A, 2'h2);
    chk("pulses", 8'h02, 8'(pulseCnt - base));
  endtask

  initial begin
    // A real falling edge lets the link-side flops see the reset.
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_good_call();
    t_bad_calls();
    t_again();
    print_verdict();
  end
endmodule
